/* bench/cdc_ctrl_chk.sv */
// Checker for the clock switch and divider control block.
// Sees only the top module ports; bound from the testbench top file.
`timescale 1ns/100ps
module cdc_ctrl_chk
    import cdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic irq_i,
    input wire logic switch_ack_i,
    input wire logic [15:0] rdata_o,
    input wire logic switch_req_o,
    input wire logic [2:0] new_source_o,
    input wire logic [2:0] current_source_o,
    input wire logic [7:0] cpu_slowdown_div_o,
    input wire logic [8:0] rc_postscaler_div_o,
    input wire logic [3:0] pll_output_div_o,
    input wire logic [5:0] pll_input_div_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    logic [15:0] w1_q, w2_q;
    wire logic dw = wr_i && addr_i == CDC_ADDR_CLK_DIV;
    wire logic ua1 = wr_i && addr_i == CDC_ADDR_UNLOCK && wdata_i == CDC_UNLOCK_KEY1;
    wire logic ua2 = wr_i && addr_i == CDC_ADDR_UNLOCK && wdata_i == CDC_UNLOCK_KEY2;
    wire logic wo = wr_i && addr_i == CDC_ADDR_OSC_CTRL;
    // Write data delayed to line up with the two-cycle divisor lag
    always_ff @(posedge clk_i) begin
        w1_q <= wdata_i;
        w2_q <= w1_q;
    end
    property p_pre;
        dw |-> ##2 pll_input_div_o == w2_q[4:0] + 6'h2;
    endproperty
    property p_frc;
        dw |-> ##2 rc_postscaler_div_o == (w2_q[10:8] == 3'h7 ? 9'h100 : 9'h1 << w2_q[10:8]);
    endproperty
    property p_post;
        dw |-> ##2 pll_output_div_o == (w2_q[7:6] == 2'h3 ? 4'h8 :
            w2_q[7:6] == 2'h2 ? 4'h0 : 4'h2 << w2_q[7:6]);
    endproperty
    property p_cpu_slowdown_ratio;
        dw && !wdata_i[CDC_ROI_BIT] && !irq_i |-> ##2
            cpu_slowdown_div_o == (w2_q[11] ? 8'h1 << w2_q[14:12] : 8'h1);
    endproperty
    property p_roi;
        dw && wdata_i[15] && wdata_i[11] ##1 irq_i && !dw |-> ##2 cpu_slowdown_div_o == 8'h1;
    endproperty
    property p_unlock;
        ua1 ##1 ua2 ##1 wo && wdata_i[0] && !switch_req_o |=>
            switch_req_o && new_source_o == w1_q[10:8];
    endproperty
    property p_locked;
        wo && !$past(ua2) |=> $stable(new_source_o) && !$rose(switch_req_o);
    endproperty
    property p_settle;
        $rose(switch_req_o) |-> switch_req_o[*8];
    endproperty
    property p_done;
        $fell(switch_req_o) |-> current_source_o == new_source_o;
    endproperty
    property p_rdata;
        !(rd_i && addr_i <= CDC_ADDR_STATUS) |=> rdata_o == 16'h0;
    endproperty
    a_pre: assert property (p_pre) else $error("input prescaler divisor wrong");
    a_frc: assert property (p_frc) else $error("rc postscaler divisor wrong");
    a_post: assert property (p_post) else $error("pll output divisor wrong");
    a_cpu_slowdown_ratio: assert property (p_cpu_slowdown_ratio) else $error("slowdown divisor wrong");
    a_roi: assert property (p_roi) else $error("interrupt did not recover");
    a_unlock: assert property (p_unlock) else $error("unlocked switch not started");
    a_locked: assert property (p_locked) else $error("locked write took effect");
    a_settle: assert property (p_settle) else $error("switch ended too early");
    a_done: assert property (p_done) else $error("source wrong at switch end");
    a_rdata: assert property (p_rdata) else $error("read data outside read slot");
    c_switch: cover property ($fell(switch_req_o));
    c_roi: cover property (p_roi);
    c_locked: cover property (wo && !$past(ua2));
endmodule

/* bench/cdc_ctrl_tb.sv */
// Testbench for the clock switch and divider control block.
// Drives register port, interrupt and switch acknowledge itself.
`timescale 1ns/100ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_mismatch++; \
    $display("ERROR %0t got %h exp %h", $time, a, b); end end
module cdc_ctrl_tb;
    import cdc_pkg::*;
    logic clk_i = 0, rst_n_i = 0, wr_i = 0, rd_i = 0, irq_i = 0, switch_ack_i = 0;
    logic [3:0] addr_i = 4'h0;
    logic [15:0] wdata_i = 16'h0, rdata_o, v;
    logic switch_req_o;
    logic [2:0] new_source_o, current_source_o;
    logic [7:0] cpu_slowdown_div_o;
    logic [8:0] rc_postscaler_div_o;
    logic [3:0] pll_output_div_o;
    logic [5:0] pll_input_div_o;
    // Source order keeps a plain fast RC hop between the two PLL modes
    logic [2:0] srcs [8] = '{3'h3, 3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6, 3'h7};
    int n_mismatch = 0, n_tests = 0;
    always #5 clk_i = ~clk_i;
    cdc_ctrl DUT (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .irq_i, .switch_ack_i,
        .rdata_o, .switch_req_o, .new_source_o, .current_source_o, .cpu_slowdown_div_o,
        .rc_postscaler_div_o, .pll_output_div_o, .pll_input_div_o);
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Leaves the strobe up so unlock writes can run back to back
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        wr_i <= 1'b1;
        addr_i <= a;
        wdata_i <= d;
        @(posedge clk_i);
    endtask
    task automatic idle;
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        wr_i <= 1'b0;
        rd_i <= 1'b1;
        addr_i <= a;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 `CHK(rdata_o, e)
        @(posedge clk_i);
    endtask
    task automatic cdiv(input logic [15:0] d);
        wr(4'h1, d);
        idle();
        @(posedge clk_i);
    endtask
    task automatic pulse_irq;
        wr_i <= 1'b0;
        irq_i <= 1'b1;
        @(posedge clk_i);
        irq_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic sw(input logic [2:0] s);
        wr(CDC_ADDR_UNLOCK, CDC_UNLOCK_KEY1);
        wr(CDC_ADDR_UNLOCK, CDC_UNLOCK_KEY2);
        wr(CDC_ADDR_OSC_CTRL, {5'h0, s, 8'h1});
        idle();
        `CHK(switch_req_o, 1'b1)
        switch_ack_i <= 1'b1;
        for (int i = 0; i < 40 && switch_req_o; i++) @(posedge clk_i);
        switch_ack_i <= 1'b0;
        `CHK(switch_req_o, 1'b0)
        `CHK(current_source_o, s)
        rd(4'h0, {1'b0, s, 1'b0, s, 8'h0});
        rd(CDC_ADDR_STATUS, 16'h0000);
    endtask
    initial begin
        repeat (5000) @(posedge clk_i);
        n_mismatch++;
        give_verdict();
    end
    initial begin
        repeat (10) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(4'h1, CDC_CLOCK_DIVISOR_CONTROL_RST);
        `CHK(cpu_slowdown_div_o, 8'h1)
        `CHK(rc_postscaler_div_o, 9'h1)
        `CHK(pll_input_div_o, 6'h2)
        `CHK(pll_output_div_o, 4'h4)
        wr(4'h0, 16'h0201);
        idle();
        `CHK(switch_req_o, 1'b0)
        rd(4'h0, 16'h0000);
        foreach (srcs[i]) sw(srcs[i]);
        for (int c = 0; c < 8; c++) begin
            v = {1'b0, c[2:0], 1'b1, c[2:0], c[1:0], 1'b0, c[2:0], c[0], c[0]};
            cdiv(v);
            `CHK(cpu_slowdown_div_o, 8'h1 << c)
            `CHK(rc_postscaler_div_o, c == 7 ? 9'h100 : 9'h1 << c)
            `CHK(pll_output_div_o, c[1:0] == 3 ? 4'h8 : c[1:0] == 2 ? 4'h0 : 4'h2 << c[1:0])
            `CHK(pll_input_div_o, v[4:0] + 6'h2)
            rd(4'h1, v);
        end
        cdiv(16'h5000);
        `CHK(cpu_slowdown_div_o, 8'h1)
        wr(4'h1, 16'hc800);
        pulse_irq();
        `CHK(cpu_slowdown_div_o, 8'h1)
        rd(4'h1, 16'hc000);
        wr(4'h1, 16'h4800);
        pulse_irq();
        `CHK(cpu_slowdown_div_o, 8'h10)
        rd(4'hf, 16'h0000);
        give_verdict();
    end
endmodule
bind cdc_ctrl cdc_ctrl_chk u_chk (.clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .irq_i,
    .switch_ack_i, .rdata_o, .switch_req_o, .new_source_o, .current_source_o,
    .cpu_slowdown_div_o, .rc_postscaler_div_o, .pll_output_div_o, .pll_input_div_o);

/* verilog/cdc_ctrl.sv */
// Clock switch request handshake and clock divider register.
// Assumes irq_i and switch_ack_i are synchronous to clk_i.
//
// Decided for this implementation: strobed register access and the register addresses.
`timescale 1ns/100ps
module cdc_ctrl
    import cdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [15:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic irq_i,
    input wire logic switch_ack_i,
    output logic [15:0] rdata_o,
    output logic switch_req_o,
    output logic [2:0] new_source_o,
    output logic [2:0] current_source_o,
    output logic [7:0] cpu_slowdown_div_o,
    output logic [8:0] rc_postscaler_div_o,
    output logic [3:0] pll_output_div_o,
    output logic [5:0] pll_input_div_o
);
    // Async assert, sync release, so no flop leaves reset on a split edge
    logic rst_s1_q;
    logic rst_q;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_s1_q <= 1'b0;
            rst_q <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_q <= rst_s1_q;
        end
    end

    // Switch sequencer state
    cdc_sw_state_t sw_d;
    cdc_sw_state_t sw_q;
    // Unlock sequence state
    cdc_ul_state_t ul_d;
    cdc_ul_state_t ul_q;
    // Requested and running source
    logic [2:0] new_source_select_d;
    logic [2:0] new_source_select_q;
    logic [2:0] cosc_d;
    logic [2:0] cosc_q;
    logic switch_request_bit_d;
    logic switch_request_bit_q;
    // Divider register and read data
    logic [15:0] clock_divisor_control_d;
    logic [15:0] clock_divisor_control_q;
    logic [15:0] rdata_d;
    logic [15:0] rdata_q;
    // Settle counter, holds the switch for CDC_SETTLE_CYC cycles; an ack during it is latched
    logic [7:0] cnt_d;
    logic [7:0] cnt_q;
    logic osc_wr;
    logic ack_seen_d;
    logic ack_seen_q;

    assign osc_wr = wr_i && (addr_i == CDC_ADDR_OSC_CTRL);

    // Unlock: two key writes in back-to-back accesses open one write
    always_comb begin
        ul_d = ul_q;
        if (wr_i || rd_i) begin
            ul_d = CDC_UL_NONE;
            if (wr_i && addr_i == CDC_ADDR_UNLOCK && wdata_i == CDC_UNLOCK_KEY1) begin
                ul_d = CDC_UL_KEY1;
            end else if (wr_i && addr_i == CDC_ADDR_UNLOCK && ul_q == CDC_UL_KEY1
                         && wdata_i == CDC_UNLOCK_KEY2) begin
                ul_d = CDC_UL_OPEN;
            end
        end
    end

    always_comb begin
        sw_d = sw_q;
        new_source_select_d = new_source_select_q;
        cosc_d = cosc_q;
        switch_request_bit_d = switch_request_bit_q;
        cnt_d = cnt_q;
        ack_seen_d = ack_seen_q;
        if (osc_wr && ul_q == CDC_UL_OPEN) begin // RULE_02
            new_source_select_d = wdata_i[CDC_NEW_SOURCE_SELECT_LSB +: 3]; // RULE_10
            if (wdata_i[CDC_SWITCH_BIT] && sw_q == CDC_ST_IDLE) begin
                switch_request_bit_d = 1'b1; // RULE_01
            end
        end
        case (sw_q)
            CDC_ST_IDLE: begin
                // Illegal PLL-to-PLL hops are software's problem, not checked
                if (switch_request_bit_q) begin // RULE_01 RULE_03
                    sw_d = CDC_ST_SETTLE;
                    cnt_d = 8'(CDC_SETTLE_CYC);
                    ack_seen_d = 1'b0;
                end
            end
            CDC_ST_SETTLE: begin
                if (switch_ack_i) begin
                    ack_seen_d = 1'b1;
                end
                if (cnt_q != 8'h00) begin
                    cnt_d = cnt_q - 8'h01;
                end else if (ack_seen_q || switch_ack_i) begin
                    sw_d = CDC_ST_DONE;
                end
            end
            CDC_ST_DONE: begin
                cosc_d = new_source_select_q;
                switch_request_bit_d = 1'b0; // RULE_01
                sw_d = CDC_ST_IDLE;
            end
            default: sw_d = CDC_ST_IDLE;
        endcase
    end

    // Divider register, no unlock needed
    // Interrupt wins over a same-cycle write so a wake-up is never lost
    always_comb begin
        clock_divisor_control_d = clock_divisor_control_q;
        if (wr_i && addr_i == CDC_ADDR_CLK_DIV) begin
            clock_divisor_control_d = wdata_i & CDC_CLOCK_DIVISOR_CONTROL_WMASK;
        end
        if (irq_i && clock_divisor_control_d[CDC_ROI_BIT]) begin // RULE_04
            clock_divisor_control_d[CDC_SLOWDOWN_ENABLE_BIT] = 1'b0;
        end
    end

    // Read data is zero outside the read slot, so a bus OR of slaves works
    always_comb begin
        rdata_d = 16'h0000;
        if (rd_i) begin
            case (addr_i)
                CDC_ADDR_OSC_CTRL: rdata_d = {1'b0, cosc_q, 1'b0, new_source_select_q, 7'h00, switch_request_bit_q};
                CDC_ADDR_CLK_DIV: rdata_d = clock_divisor_control_q;
                CDC_ADDR_STATUS: rdata_d = {14'h0000, sw_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_q) begin
        if (!rst_q) begin
            sw_q <= CDC_ST_IDLE;
            ul_q <= CDC_UL_NONE;
            new_source_select_q <= CDC_NEW_SOURCE_SELECT_RST;
            cosc_q <= CDC_NEW_SOURCE_SELECT_RST;
            switch_request_bit_q <= 1'b0;
            cnt_q <= 8'h00;
            ack_seen_q <= 1'b0;
            clock_divisor_control_q <= CDC_CLOCK_DIVISOR_CONTROL_RST;
            rdata_q <= 16'h0000;
        end else begin
            sw_q <= sw_d;
            ul_q <= ul_d;
            new_source_select_q <= new_source_select_d;
            cosc_q <= cosc_d;
            switch_request_bit_q <= switch_request_bit_d;
            cnt_q <= cnt_d;
            ack_seen_q <= ack_seen_d;
            clock_divisor_control_q <= clock_divisor_control_d;
            rdata_q <= rdata_d;
        end
    end

    assign rdata_o = rdata_q;
    assign switch_req_o = switch_request_bit_q;
    assign new_source_o = new_source_select_q;
    assign current_source_o = cosc_q;

    cdc_decode u_decode (
        .clk_i(clk_i),
        .rst_n_i(rst_q),
        .cpu_slowdown_ratio_code_i(clock_divisor_control_q[CDC_CPU_SLOWDOWN_RATIO_LSB +: 3]),
        .cpu_slowdown_ratio_en_i(clock_divisor_control_q[CDC_SLOWDOWN_ENABLE_BIT]),
        .frc_code_i(clock_divisor_control_q[CDC_RC_POSTSCALER_SELECT_LSB +: 3]),
        .post_code_i(clock_divisor_control_q[CDC_POST_LSB +: 2]),
        .pre_code_i(clock_divisor_control_q[CDC_PRE_LSB +: 5]),
        .cpu_slowdown_ratio_div_o(cpu_slowdown_div_o),
        .frc_div_o(rc_postscaler_div_o),
        .post_div_o(pll_output_div_o),
        .pre_div_o(pll_input_div_o)
    );
endmodule

/* verilog/cdc_decode.sv */
// Decodes divider codes into divisor values.
// Pure registered lookup, fed by the control register fields.
`timescale 1ns/100ps
module cdc_decode
    import cdc_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [2:0] cpu_slowdown_ratio_code_i,
    input wire logic cpu_slowdown_ratio_en_i,
    input wire logic [2:0] frc_code_i,
    input wire logic [1:0] post_code_i,
    input wire logic [4:0] pre_code_i,
    output logic [7:0] cpu_slowdown_ratio_div_o,
    output logic [8:0] frc_div_o,
    output logic [3:0] post_div_o,
    output logic [5:0] pre_div_o
);
    logic [7:0] cpu_slowdown_ratio_d, cpu_slowdown_ratio_q;
    logic [8:0] frc_d, frc_q;
    logic [3:0] post_d, post_q;
    logic [5:0] pre_d, pre_q;

    always_comb begin
        cpu_slowdown_ratio_d = cpu_slowdown_ratio_en_i ? (8'h01 << cpu_slowdown_ratio_code_i) : 8'h01; // RULE_05
        frc_d = (frc_code_i == 3'h7) ? 9'h100 : (9'h001 << frc_code_i); // RULE_06
        case (post_code_i) // RULE_07
            2'h0: post_d = 4'h2;
            2'h1: post_d = 4'h4;
            2'h3: post_d = 4'h8;
            default: post_d = 4'h0;
        endcase
        pre_d = {1'b0, pre_code_i} + 6'h02; // RULE_08 RULE_09
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            // Slowdown is disabled at reset, so the ratio shown is 1:1
            cpu_slowdown_ratio_q <= 8'h01;
            frc_q <= 9'h001;
            post_q <= 4'h4;
            pre_q <= 6'h02;
        end else begin
            cpu_slowdown_ratio_q <= cpu_slowdown_ratio_d;
            frc_q <= frc_d;
            post_q <= post_d;
            pre_q <= pre_d;
        end
    end

    assign cpu_slowdown_ratio_div_o = cpu_slowdown_ratio_q;
    assign frc_div_o = frc_q;
    assign post_div_o = post_q;
    assign pre_div_o = pre_q;
endmodule

/* verilog/cdc_pkg.sv */
// Constants for the clock switch and divider control block.
// Assumes a single 100 MHz clock and a plain address/strobe register port.
// Overview of operation
// RULE_01 - Setting the switch request bit starts a switch to the selected new source and the bit clears once the switch is done.
// RULE_02 - Oscillator control writes take effect only right after the unlock sequence, other writes are ignored.
// RULE_03 - Software must pass through plain fast RC when going between the two PLL modes.
// RULE_04 - With recover on interrupt set, an interrupt clears slowdown enable so the ratio becomes 1:1.
// RULE_05 - With slowdown enabled the three-bit ratio code selects divide by 1 up to 128, otherwise the ratio is 1:1.
// RULE_06 - The fast RC postscaler code selects divide by 1, 2, 4, 8, 16, 32, 64 or 256, default 1.
// RULE_07 - The PLL output divider code selects 2, 4, reserved or 8.
// RULE_08 - The PLL input prescaler divides by 2 at code 0 and 3 at code 1, rising with the code.
// RULE_09 - The input prescaler divisor is the code plus two.
// RULE_10 - The new source code maps to fast RC, fast RC with PLL, primary, primary with PLL, secondary, low power RC, RC/16, RC/n.
package cdc_pkg;
    localparam logic [3:0] CDC_ADDR_OSC_CTRL = 4'h0;
    localparam logic [3:0] CDC_ADDR_CLK_DIV = 4'h1;
    localparam logic [3:0] CDC_ADDR_UNLOCK = 4'h2;
    localparam logic [3:0] CDC_ADDR_STATUS = 4'h3;
    localparam logic [15:0] CDC_UNLOCK_KEY1 = 16'h0046;
    localparam logic [15:0] CDC_UNLOCK_KEY2 = 16'h0057;
    localparam int CDC_SWITCH_BIT = 0;
    localparam int CDC_NEW_SOURCE_SELECT_LSB = 8;
    localparam int CDC_ROI_BIT = 15;
    localparam int CDC_CPU_SLOWDOWN_RATIO_LSB = 12;
    localparam int CDC_SLOWDOWN_ENABLE_BIT = 11;
    localparam int CDC_RC_POSTSCALER_SELECT_LSB = 8;
    localparam int CDC_POST_LSB = 6;
    localparam int CDC_PRE_LSB = 0;
    localparam logic [15:0] CDC_CLOCK_DIVISOR_CONTROL_RST = 16'h3040;
    localparam logic [15:0] CDC_CLOCK_DIVISOR_CONTROL_WMASK = 16'hffdf;
    localparam logic [2:0] CDC_NEW_SOURCE_SELECT_RST = 3'h0;
    localparam int CDC_SETTLE_NS = 100;
    localparam int CDC_CLK_MHZ = 100;
    localparam int CDC_SETTLE_CYC = (CDC_SETTLE_NS * CDC_CLK_MHZ + 999) / 1000;
    localparam logic [2:0] CDC_SRC_FRC = 3'h0;
    localparam logic [2:0] CDC_SRC_FAST_RC_WITH_PLL = 3'h1;
    localparam logic [2:0] CDC_SRC_PRI = 3'h2;
    localparam logic [2:0] CDC_SRC_PRIPLL = 3'h3;
    localparam logic [2:0] CDC_SRC_SEC = 3'h4;
    localparam logic [2:0] CDC_SRC_LOW_POWER_RC = 3'h5;
    localparam logic [2:0] CDC_SRC_FRC16 = 3'h6;
    localparam logic [2:0] CDC_SRC_FRCN = 3'h7;
    typedef enum logic [1:0] {
        CDC_ST_IDLE = 2'b00,
        CDC_ST_SETTLE = 2'b01,
        CDC_ST_DONE = 2'b10
    } cdc_sw_state_t;
    typedef enum logic [1:0] {
        CDC_UL_NONE = 2'b00,
        CDC_UL_KEY1 = 2'b01,
        CDC_UL_OPEN = 2'b10
    } cdc_ul_state_t;
endpackage
